// file: logic/irpdd_pkg.sv
// Constants and state types of the infrared pulse-distance decoder
`default_nettype none
package irpdd_pkg;
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL    = 12'h000; // Control and config
   localparam logic [11:0] ADDR_EXPECT  = 12'h004; // Expected bit count
   localparam logic [11:0] ADDR_TIMEOUT = 12'h008; // Timeout preload
   localparam logic [11:0] ADDR_THRESH  = 12'h00C; // Threshold compare
   localparam logic [11:0] ADDR_STATUS  = 12'h010; // Status and count
   localparam logic [11:0] ADDR_DATA    = 12'h020; // First data word
   localparam logic [11:0] DATA_MASK    = 12'hFE0; // Data window match
   // Control fields
   localparam int CTRL_START = 0;  // Write 1 to begin a read
   localparam int CTRL_INV   = 1;  // Rising edges when set
   localparam int CTRL_PIN   = 2;  // Two-bit pin select
   localparam int CTRL_PRIV  = 4;  // Private timer on pin 0
   localparam int CTRL_PSC   = 8;  // Three-bit prescaler
   // Status fields
   localparam int STAT_BUSY  = 0;  // Read in progress
   localparam int STAT_DONE  = 1;  // Read ended
   localparam int STAT_SHORT = 2;  // Fewer bits than expected
   localparam int STAT_LIMIT = 3;  // Ended on the cycle limit
   localparam int STAT_PRIV  = 4;  // Private timer in use
   localparam int STAT_CNT   = 16; // Nine-bit received count
   // Reset values
   localparam logic [2:0]  PSC_RST     = 3'h6;   // Prescaler after reset
   localparam logic [8:0]  EXPECT_RST  = 9'h020; // Expected bits
   localparam logic [15:0] TIMEOUT_RST = 16'h0000;
   localparam logic [15:0] THRESH_RST  = 16'h0000;
   // Limits
   localparam logic [8:0]  MAX_CYC     = 9'h100; // Cycle limit
   localparam logic [15:0] TMR_TOP     = 16'hFFFF; // Overflow value
   localparam int          DATA_WORDS  = 8;      // 256 bits / 32
   // Decoder states
   typedef enum logic [1:0] {
      IRPDD_IDLE,
      IRPDD_ARMED,
      IRPDD_RUN
   } irpdd_state_e;
   // All state of the decoder
   typedef struct packed {
      irpdd_state_e  st;      // Sequencer state
      logic          inv;     // Edge polarity select
      logic [1:0]    pin;     // Capture pin select
      logic          priv;    // Private timer request
      logic [2:0]    psc;     // Prescaler setting
      logic [8:0]    exp_cnt; // Expected bits
      logic [15:0]   preload; // Timeout preload
      logic [15:0]   thresh;  // Threshold plus preload
      logic [15:0]   timer;   // Up-counting timer
      logic [15:0]   pscnt;   // Prescaler counter
      logic          prev;    // Previous pin level
      logic [8:0]    count;   // Bits decoded
      logic [255:0]  bits;    // Decoded bit buffer
      logic          done;    // Read ended
      logic          short_rx;// Short read
      logic          limit;   // Ended on limit
      logic [31:0]   prdata;  // Read data
      logic          pready;  // Bus ready
      logic          pslverr; // Bus error
      logic          shr_busy;// Shared timer in use
      logic          prv_busy;// Private timer in use
   } irpdd_regs_s;
endpackage
`default_nettype wire

// file: logic/irpdd_top.sv
// Infrared pulse-distance decoder with APB register access
// Behaviour
// - Time falling edges; rising when inverted
// - Longer than threshold is one, else zero
// - Report actual number of decoded bits
// - Short read ends after silent timeout
// - Full read ends after silent timeout
// - End after 256 counted input cycles
// - Store bits one by one, individually readable
// - Four pins; pin zero may use private timer
// - Eight prescaler settings, six after reset
// - Step doubles per setting, older family
// - Step doubles per setting, newer family
// - Steps scale inversely with clock rate
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module irpdd_top #(
   parameter int BASE_SH = 0 // Log2 of clocks per step at setting 0
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  cap_pin,
   output logic             done,
   output logic             shr_busy,
   output logic             prv_busy
);

   irpdd_pkg::irpdd_regs_s s_r;   // Registered state
   irpdd_pkg::irpdd_regs_s s_nxt; // Next state

   logic        cur;       // Selected pin level
   logic        act_edge;  // Active edge this cycle
   logic        tick;      // Timer count step
   logic        ovf;       // Timer overflow
   logic        wr_acc;    // Write taking effect
   logic        start;     // Start request accepted
   logic [31:0] rdata;     // Read mux output
   logic        rmapped;   // Address is mapped

   // Mask of prescaler bits that must be all ones for a step
   function automatic logic [15:0] tick_mask(input logic [2:0] psc);
      logic [15:0] m;
      m = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         m[i] = (i < (int'(psc) + BASE_SH));
      end
      return m;
   endfunction

   // Address falls in the data word window
   function automatic logic is_data(input logic [11:0] a);
      return (a & irpdd_pkg::DATA_MASK) == irpdd_pkg::ADDR_DATA;
   endfunction

   // Pin selection and edge detection
   always_comb begin
      cur = cap_pin[s_r.pin];
      // Falling by default, rising when inverted
      act_edge = s_r.inv ? (cur & ~s_r.prev) : (~cur & s_r.prev);
      // Step every 2^(psc+BASE_SH) clocks
      tick = (s_r.pscnt & tick_mask(s_r.psc)) == tick_mask(s_r.psc);
      ovf  = tick && (s_r.timer == irpdd_pkg::TMR_TOP);
   end

   // Read data mux
   always_comb begin
      rdata   = 32'h0000_0000;
      rmapped = 1'b1;
      if (paddr == irpdd_pkg::ADDR_CTRL) begin
         rdata[irpdd_pkg::CTRL_INV]         = s_r.inv;
         rdata[irpdd_pkg::CTRL_PIN +: 2]    = s_r.pin;
         rdata[irpdd_pkg::CTRL_PRIV]        = s_r.priv;
         rdata[irpdd_pkg::CTRL_PSC +: 3]    = s_r.psc;
      end else if (paddr == irpdd_pkg::ADDR_EXPECT) begin
         rdata[8:0] = s_r.exp_cnt;
      end else if (paddr == irpdd_pkg::ADDR_TIMEOUT) begin
         rdata[15:0] = s_r.preload;
      end else if (paddr == irpdd_pkg::ADDR_THRESH) begin
         rdata[15:0] = s_r.thresh;
      end else if (paddr == irpdd_pkg::ADDR_STATUS) begin
         rdata[irpdd_pkg::STAT_BUSY]  = (s_r.st != irpdd_pkg::IRPDD_IDLE);
         rdata[irpdd_pkg::STAT_DONE]  = s_r.done;
         rdata[irpdd_pkg::STAT_SHORT] = s_r.short_rx;
         rdata[irpdd_pkg::STAT_LIMIT] = s_r.limit;
         rdata[irpdd_pkg::STAT_PRIV]  = s_r.prv_busy;
         // Actual number of bits decoded
         rdata[irpdd_pkg::STAT_CNT +: 9] = s_r.count;
      end else if (is_data(paddr)) begin
         // Each bit readable in its own position
         rdata = s_r.bits[paddr[4:2]*32 +: 32];
      end else begin
         rmapped = 1'b0;
      end
   end

   // Bus handshake terms
   always_comb begin
      wr_acc = psel && penable && s_r.pready && pwrite;
      start  = wr_acc && (paddr == irpdd_pkg::ADDR_CTRL)
               && pwdata[irpdd_pkg::CTRL_START]
               && (s_r.st == irpdd_pkg::IRPDD_IDLE);
   end

   // Next-state logic
   always_comb begin
      s_nxt       = s_r;
      s_nxt.prev  = cur;
      s_nxt.pscnt = 16'(s_r.pscnt + 16'h0001);
      // Ready one cycle after setup, error for unmapped address
      s_nxt.pready  = psel && !penable;
      s_nxt.pslverr = psel && !penable && !rmapped;
      if (psel && !penable) begin
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rdata;
      end
      // Configuration writes only while idle
      if (wr_acc && (s_r.st == irpdd_pkg::IRPDD_IDLE)) begin
         if (paddr == irpdd_pkg::ADDR_CTRL) begin
            s_nxt.inv  = pwdata[irpdd_pkg::CTRL_INV];
            s_nxt.pin  = pwdata[irpdd_pkg::CTRL_PIN +: 2];
            s_nxt.priv = pwdata[irpdd_pkg::CTRL_PRIV];
            s_nxt.psc  = pwdata[irpdd_pkg::CTRL_PSC +: 3];
         end else if (paddr == irpdd_pkg::ADDR_EXPECT) begin
            s_nxt.exp_cnt = pwdata[8:0];
         end else if (paddr == irpdd_pkg::ADDR_TIMEOUT) begin
            s_nxt.preload = pwdata[15:0];
         end else if (paddr == irpdd_pkg::ADDR_THRESH) begin
            s_nxt.thresh = pwdata[15:0];
         end
      end
      // Sequencer
      case (s_r.st)
         irpdd_pkg::IRPDD_IDLE: begin
            if (start) begin
               s_nxt.st       = irpdd_pkg::IRPDD_ARMED;
               s_nxt.count    = 9'h000;
               s_nxt.bits     = '0;
               s_nxt.done     = 1'b0;
               s_nxt.short_rx = 1'b0;
               s_nxt.limit    = 1'b0;
               s_nxt.timer    = s_r.preload;
               s_nxt.pscnt    = 16'h0000;
               // Compare against the new pin, not the old one
               s_nxt.prev     = cap_pin[pwdata[irpdd_pkg::CTRL_PIN +: 2]];
               // Pins 1 to 3 always take the shared timer
               // Timer choice follows the control word being written
               if (pwdata[irpdd_pkg::CTRL_PRIV]
                   && (pwdata[irpdd_pkg::CTRL_PIN +: 2] == 2'h0)) begin
                  s_nxt.prv_busy = 1'b1;
               end else begin
                  s_nxt.shr_busy = 1'b1;
               end
            end
         end
         irpdd_pkg::IRPDD_ARMED: begin
            if (act_edge) begin
               // First edge only starts timing
               s_nxt.st    = irpdd_pkg::IRPDD_RUN;
               s_nxt.timer = s_r.preload;
            end else if (ovf) begin
               // No edge within the timeout
               s_nxt.st       = irpdd_pkg::IRPDD_IDLE;
               s_nxt.done     = 1'b1;
               s_nxt.short_rx = (s_r.exp_cnt != 9'h000);
               s_nxt.shr_busy = 1'b0;
               s_nxt.prv_busy = 1'b0;
            end else if (tick) begin
               s_nxt.timer = 16'(s_r.timer + 16'h0001);
            end
         end
         irpdd_pkg::IRPDD_RUN: begin
            if (act_edge) begin
               // Decode against threshold and store in order
               s_nxt.bits[s_r.count[7:0]] = (s_r.timer > s_r.thresh);
               s_nxt.count = 9'(s_r.count + 9'h001);
               s_nxt.timer = s_r.preload;
               if (9'(s_r.count + 9'h001) == irpdd_pkg::MAX_CYC) begin
                  // Continuous input ends at the cycle limit
                  s_nxt.st       = irpdd_pkg::IRPDD_IDLE;
                  s_nxt.done     = 1'b1;
                  s_nxt.limit    = 1'b1;
                  s_nxt.short_rx = (irpdd_pkg::MAX_CYC < s_r.exp_cnt);
                  s_nxt.shr_busy = 1'b0;
                  s_nxt.prv_busy = 1'b0;
               end
            end else if (ovf) begin
               // Silence ends both short and full reads
               s_nxt.st       = irpdd_pkg::IRPDD_IDLE;
               s_nxt.done     = 1'b1;
               s_nxt.short_rx = (s_r.count < s_r.exp_cnt);
               s_nxt.shr_busy = 1'b0;
               s_nxt.prv_busy = 1'b0;
            end else if (tick) begin
               s_nxt.timer = 16'(s_r.timer + 16'h0001);
            end
         end
         default: begin
            s_nxt.st = irpdd_pkg::IRPDD_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r          <= '0;
         s_r.st       <= irpdd_pkg::IRPDD_IDLE;
         s_r.psc      <= irpdd_pkg::PSC_RST;
         s_r.exp_cnt  <= irpdd_pkg::EXPECT_RST;
         s_r.preload  <= irpdd_pkg::TIMEOUT_RST;
         s_r.thresh   <= irpdd_pkg::THRESH_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops
   assign prdata   = s_r.prdata;
   assign pready   = s_r.pready;
   assign pslverr  = s_r.pslverr;
   assign done     = s_r.done;
   assign shr_busy = s_r.shr_busy;
   assign prv_busy = s_r.prv_busy;

   // Edge seen while measuring
   sequence s_run_edge;
      (s_r.st == irpdd_pkg::IRPDD_RUN) && act_edge;
   endsequence

   // Read has ended
   sequence s_ended;
      (s_r.st == irpdd_pkg::IRPDD_IDLE) && s_r.done && !shr_busy && !prv_busy;
   endsequence

   // An edge adds exactly one bit
   property p_edge_count;
      @(posedge pclk) disable iff (!presetn)
      s_run_edge |=> s_r.count == 9'($past(s_r.count) + 9'h001);
   endproperty
   a_edge_count: assert property (p_edge_count)
      else $error("edge did not add one bit");

   // Stored bit matches the threshold compare
   property p_bit_val;
      @(posedge pclk) disable iff (!presetn)
      s_run_edge |=> s_r.bits[$past(s_r.count[7:0])] ==
                     ($past(s_r.timer) > $past(s_r.thresh));
   endproperty
   a_bit_val: assert property (p_bit_val)
      else $error("decoded bit wrong");

   // Overflow without edge ends the read
   property p_timeout;
      @(posedge pclk) disable iff (!presetn)
      (s_r.st != irpdd_pkg::IRPDD_IDLE) && ovf && !act_edge |=> s_ended;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout did not end read");

   // Full read still waits for silence
   property p_full_wait;
      @(posedge pclk) disable iff (!presetn)
      (s_run_edge and ((s_r.count >= s_r.exp_cnt) &&
      (s_r.count < 9'h0FF))) |=> (s_r.st == irpdd_pkg::IRPDD_RUN);
   endproperty
   a_full_wait: assert property (p_full_wait)
      else $error("read ended before silence");

   // Cycle limit ends the read
   property p_limit;
      @(posedge pclk) disable iff (!presetn)
      (s_run_edge and (s_r.count == 9'h0FF)) |=> s_ended ##0 s_r.limit
         ##0 (s_r.count == irpdd_pkg::MAX_CYC);
   endproperty
   a_limit: assert property (p_limit)
      else $error("cycle limit missed");

   // Any edge during a read reloads the timer
   property p_reload;
      @(posedge pclk) disable iff (!presetn)
      (s_r.st != irpdd_pkg::IRPDD_IDLE) && act_edge
      |=> s_r.timer == $past(s_r.preload);
   endproperty
   a_reload: assert property (p_reload)
      else $error("timer not reloaded on edge");

   // First edge produces no bit
   property p_first;
      @(posedge pclk) disable iff (!presetn)
      (s_r.st == irpdd_pkg::IRPDD_ARMED) && act_edge
      |=> (s_r.st == irpdd_pkg::IRPDD_RUN) && (s_r.count == 9'h000);
   endproperty
   a_first: assert property (p_first)
      else $error("first edge decoded a bit");

   // Timer holds between steps
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (s_r.st != irpdd_pkg::IRPDD_IDLE) && !tick && !act_edge
      |=> s_r.timer == $past(s_r.timer);
   endproperty
   a_hold: assert property (p_hold)
      else $error("timer moved without a step");

   // Pins other than zero never use the private timer
   property p_shared;
      @(posedge pclk) disable iff (!presetn)
      (s_r.pin != 2'h0) |-> !prv_busy;
   endproperty
   a_shared: assert property (p_shared)
      else $error("private timer on shared pin");

   // Prescaler comes out of reset at setting six
   property p_psc_rst;
      @(posedge pclk) $rose(presetn) |-> s_r.psc == irpdd_pkg::PSC_RST;
   endproperty
   a_psc_rst: assert property (p_psc_rst)
      else $error("prescaler reset value wrong");

   // Start clears the count and the end flag
   property p_arm;
      @(posedge pclk) disable iff (!presetn)
      start |=> (s_r.st == irpdd_pkg::IRPDD_ARMED) && (s_r.count == 9'h000)
         && !done;
   endproperty
   a_arm: assert property (p_arm)
      else $error("start did not clear the read");

   // Pin zero with the private request takes the private timer
   property p_private;
      @(posedge pclk) disable iff (!presetn)
      start && pwdata[irpdd_pkg::CTRL_PRIV]
      && (pwdata[irpdd_pkg::CTRL_PIN +: 2] == 2'h0)
      |=> prv_busy && !shr_busy;
   endproperty
   a_private: assert property (p_private)
      else $error("private timer not taken on pin zero");

endmodule // irpdd_top
`default_nettype wire

// file: sim/irpdd_ir_rx.sv
// Behavioural infrared receiver that drives the decoder's capture pins
`timescale 1ns/1ps
`default_nettype none
module irpdd_ir_rx (
   input  wire logic       pclk,
   output logic      [3:0] cap_pin
);
   // Pins rest high, the idle level of a non-inverted receiver
   initial begin
      cap_pin = 4'hF;
   end
   // Return every pin to the idle level of the chosen polarity
   task automatic park(input logic inv);
      @(posedge pclk);
      cap_pin <= {4{~inv}};
   endtask
   // One leading active edge, then one cycle of length l0 or l1 per bit
   task automatic send(input logic [1:0] pin, input logic inv,
                       input int n, input logic [31:0] pat,
                       input int l0, input int l1);
      int len;
      @(posedge pclk);
      cap_pin[pin] <= inv;
      for (int i = 0; i < n; i++) begin
         len = pat[i % 32] ? l1 : l0;
         // Short active phase, then the rest of the cycle inactive
         repeat (4) @(posedge pclk);
         cap_pin[pin] <= ~inv;
         repeat (len - 4) @(posedge pclk);
         cap_pin[pin] <= inv;
      end
      repeat (4) @(posedge pclk);
      cap_pin[pin] <= ~inv;
   endtask
endmodule // irpdd_ir_rx
`default_nettype wire

// file: sim/tb_ir_pulse_distance_decoder.sv
// Self-checking testbench of the infrared pulse-distance decoder
`timescale 1ns/1ps
`default_nettype none
module tb_ir_pulse_distance_decoder;
   logic        pclk    = 1'b0;  // 125 MHz clock
   logic        presetn = 1'b0;  // Reset, active low
   logic        psel    = 1'b0;  // Bus select
   logic        penable = 1'b0;  // Bus access phase
   logic        pwrite  = 1'b0;  // Bus direction
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h00000000;
   logic [31:0] prdata;
   logic        pready, pslverr, done, shr_busy, prv_busy;
   logic [3:0]  cap_pin;         // Driven by the receiver model
   int          fails   = 0;     // Mismatch count
   int          checks  = 0;     // Comparison count
   // Timeout of 64 counts, threshold 20 counts past the preload
   localparam logic [15:0] TMO = 16'hFFC0;
   localparam logic [15:0] THR = 16'hFFD4;
   // Clock of period 8 ns
   always #4 pclk = ~pclk;
   irpdd_top #(.BASE_SH(0)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin),
      .done(done), .shr_busy(shr_busy), .prv_busy(prv_busy));
   irpdd_ir_rx u_ir (.pclk(pclk), .cap_pin(cap_pin));
   // Print the counts and the verdict, then stop
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Compare a word
   task automatic chk32(input logic [31:0] g, input logic [31:0] e,
                        input string w);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t %s got %h want %h", $time, w, g, e);
      end
   endtask
   // Compare a flag
   task automatic chk1(input logic g, input logic e, input string w);
      chk32({31'h0, g}, {31'h0, e}, w);
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         $display("[ERR] %0t bus answer missing", $time);
         final_report();
      end
   endtask
   // Register write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        y;
      apb(1'b1, a, d, x, y);
   endtask
   // Register read compared under a mask, with the error flag
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                         input logic [31:0] e, input logic ee);
      logic [31:0] d;
      logic        er;
      apb(1'b0, a, 32'h00000000, d, er);
      chk32(d & m, e, "read data");
      chk1(er, ee, "slave error");
   endtask
   // Status: count and flags {priv, limit, short, done, busy}
   task automatic chk_stat(input logic [8:0] c, input logic [4:0] f);
      rd_chk(irpdd_pkg::ADDR_STATUS, 32'hFFFFFFFF, {7'h0, c, 11'h0, f},
             1'b0);
   endtask
   // Wait for the end of a read under a bound
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      if (done !== 1'b1) begin
         fails++;
         $display("[ERR] %0t read never ended", $time);
         final_report();
      end
   endtask
   // Configure, start, check timer use, send a stream, wait for the end
   task automatic frame(input logic [1:0] pin, input logic inv,
                        input logic prv, input logic [2:0] psc,
                        input logic [8:0] ex, input int n,
                        input logic [31:0] pat, input int l0, input int l1);
      wr(irpdd_pkg::ADDR_EXPECT, {23'h0, ex});
      wr(irpdd_pkg::ADDR_TIMEOUT, {16'h0, TMO});
      wr(irpdd_pkg::ADDR_THRESH, {16'h0, THR});
      u_ir.park(inv);
      wr(irpdd_pkg::ADDR_CTRL, {21'h0, psc, 3'h0, prv, pin, inv, 1'b1});
      repeat (2) @(posedge pclk);
      chk1(shr_busy, !(prv && pin == 2'h0), "shared use");
      chk1(prv_busy, prv && pin == 2'h0, "private use");
      chk_stat(9'h000, {prv && pin == 2'h0, 3'h0, 1'b1});
      u_ir.send(pin, inv, n, pat, l0, l1);
      wait_done();
      u_ir.park(1'b0);
   endtask
   // Reset values and an unmapped address
   task automatic t_reset();
      rd_chk(irpdd_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h00000600, 1'b0);
      rd_chk(irpdd_pkg::ADDR_EXPECT, 32'hFFFFFFFF, 32'h00000020, 1'b0);
      rd_chk(irpdd_pkg::ADDR_THRESH, 32'hFFFFFFFF, 32'h00000000, 1'b0);
      rd_chk(irpdd_pkg::ADDR_TIMEOUT, 32'hFFFFFFFF, 32'h00000000, 1'b0);
      chk_stat(9'h000, 5'h00);
      rd_chk(12'h014, 32'hFFFFFFFF, 32'h00000000, 1'b1);
      $display("%0t reset test done", $time);
   endtask
   // Full 32-bit frame, then silence
   task automatic t_full();
      frame(2'd0, 1'b0, 1'b0, 3'h0, 9'h020, 32, 32'hA5C30F96, 12, 30);
      chk_stat(9'h020, 5'h02);
      rd_chk(irpdd_pkg::ADDR_DATA, 32'hFFFFFFFF, 32'hA5C30F96, 1'b0);
      $display("%0t full frame test done", $time);
   endtask
   // Fewer bits than expected end on the timeout
   task automatic t_short();
      frame(2'd0, 1'b0, 1'b0, 3'h0, 9'h020, 5, 32'h00000016, 12, 30);
      chk_stat(9'h005, 5'h06);
      rd_chk(irpdd_pkg::ADDR_DATA, 32'h0000001F, 32'h00000016, 1'b0);
      $display("%0t short read test done", $time);
   endtask
   // Rising edges on pin 3, private request ignored there
   task automatic t_inv();
      frame(2'd3, 1'b1, 1'b1, 3'h0, 9'h008, 8, 32'h000000C9, 12, 30);
      chk_stat(9'h008, 5'h02);
      rd_chk(irpdd_pkg::ADDR_DATA, 32'h000000FF, 32'h000000C9, 1'b0);
      $display("%0t inverted test done", $time);
   endtask
   // Slower prescaler on the private timer: a 30-cycle period reads zero
   task automatic t_psc();
      frame(2'd0, 1'b0, 1'b1, 3'h1, 9'h004, 4, 32'h0000000A, 30, 60);
      chk_stat(9'h004, 5'h02);
      rd_chk(irpdd_pkg::ADDR_DATA, 32'h0000000F, 32'h0000000A, 1'b0);
      $display("%0t prescaler test done", $time);
   endtask
   // Stream without a gap stops at 256 cycles
   task automatic t_limit();
      frame(2'd0, 1'b0, 1'b0, 3'h0, 9'h020, 300, 32'hAAAAAAAA, 12, 30);
      chk_stat(9'h100, 5'h0A);
      for (int i = 0; i < irpdd_pkg::DATA_WORDS; i++) begin
         rd_chk(irpdd_pkg::ADDR_DATA + 12'(4 * i), 32'hFFFFFFFF,
                32'hAAAAAAAA, 1'b0);
      end
      $display("%0t cycle limit test done", $time);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_full();
      t_short();
      t_inv();
      t_psc();
      t_limit();
      final_report();
   end
endmodule // tb_ir_pulse_distance_decoder
`default_nettype wire
